// ---- logic/epc_pkg.sv ----
// Package with register map, field positions and array geometry for program control
package epc_pkg;
  // Register offsets on the control port
  localparam logic [7:0] EEPROM_PROGRAM_CONTROL_ADDR = 8'h1B;
  localparam logic [7:0] EPROM_PROGRAM_CONTROL_ADDR  = 8'h1C;

  // Field positions in the EEPROM program control register
  localparam int CHARGE_PUMP_ENABLE_BIT = 6;
  localparam int ERASE_SELECT_HIGH_BIT  = 4;
  localparam int ERASE_SELECT_LOW_BIT   = 3;
  localparam int EEPROM_LATCH_BIT       = 2;
  localparam int RC_CLOCK_SELECT_BIT    = 1;
  localparam int EEPROM_POWER_APPLY_BIT = 0;

  // Field positions in the EPROM program control register
  localparam int EPROM_BUS_CAPTURE_BIT  = 1;
  localparam int EPROM_POWER_APPLY_BIT  = 0;

  // Reset values
  localparam logic [7:0] EEPROM_CONTROL_RESET = 8'h00;
  localparam logic [1:0] EPROM_CONTROL_RESET  = 2'h0;

  // EEPROM array geometry
  localparam logic [15:0] EEPROM_BASE  = 16'h0300;
  localparam logic [15:0] EEPROM_LAST  = 16'h03EF;
  localparam int          EEPROM_BYTES = 240;
  localparam int          BLOCK_BITS   = 6;

  // Erased values of the arrays
  localparam logic [7:0] EEPROM_ERASED = 8'h00;
  localparam logic [7:0] EPROM_ERASED  = 8'h00;

  // Erase select encodings
  typedef enum logic [1:0] {
    EPC_MODE_PROGRAM    = 2'b00,
    EPC_MODE_BYTE_ERASE = 2'b01,
    EPC_MODE_BLOCK_ERASE = 2'b10,
    EPC_MODE_BULK_ERASE = 2'b11
  } epc_mode_type;
endpackage

// ---- logic/epc_program_control.sv ----
// EEPROM and EPROM programming control registers with bus capture latches
//
// Overview of operation
// - Pump enable bit drives the charge pump
// - Pump voltage reaches array only with power
// - Erase field: program, byte, block, bulk
// - Erase bits read/write, reset to program
// - Byte erase clears only latched byte
// - Block erase clears whole block (64 bytes, last one 48)
// - Bulk erase clears all 240 bytes
// - Latch set: EEPROM writes capture address, data
// - Latch set blocks EEPROM array reads
// - RC select picks RC or CPU clock
// - EEPROM power needs prior latch, auto-clears
// - Latch and power never set together
// - EPROM latch captures writes, blocks reads
// - EPROM power needs prior latch, auto-clears
// - EPROM latch and power set separately
// - Erased EPROM reads zero, program sets ones
// - EPROM bits reset to zero, rest undefined
`timescale 1ns/1ps
module epc_program_control #(
  parameter int ADDR_WIDTH = 16
) (
  input  wire logic                  clk,
  input  wire logic                  srst,
  // Control register port
  input  wire logic [7:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_write,
  input  wire logic                  reg_read,
  output logic      [7:0]            reg_rdata,
  // Processor access to the EEPROM space
  input  wire logic [ADDR_WIDTH-1:0] ee_addr,
  input  wire logic [7:0]            ee_wdata,
  input  wire logic                  ee_write,
  input  wire logic                  ee_read,
  output logic      [7:0]            ee_rdata,
  // Processor access to the EPROM space
  input  wire logic [ADDR_WIDTH-1:0] ep_addr,
  input  wire logic [7:0]            ep_wdata,
  input  wire logic                  ep_write,
  input  wire logic                  ep_read,
  output logic      [7:0]            ep_rdata,
  // Array control outputs
  output logic                       charge_pump_on,
  output logic                       eeprom_power,
  output logic                       rc_clock_on,
  output logic                       eprom_power,
  output logic      [ADDR_WIDTH-1:0] eprom_latched_addr,
  output logic      [7:0]            eprom_latched_data,
  output logic                       eprom_latch_valid
);

  localparam int EE_INDEX_W = 8;
  localparam int EP_DEPTH   = 256;

  // Control register bits
  logic       charge_pump_enable;
  logic [1:0] erase_select;
  logic       eeprom_latch;
  logic       rc_clock_select;
  logic       eeprom_power_apply;
  logic       eprom_bus_capture;
  logic       eprom_power_apply;
  logic [5:0] eprom_upper_bits;

  // EEPROM capture latches
  logic [ADDR_WIDTH-1:0] ee_latched_addr;
  logic [7:0]            ee_latched_data;
  logic                  ee_latch_valid;

  // Array depth, declared before the arrays that use it
  localparam int EEPROM_BYTES_L = epc_pkg::EEPROM_BYTES;

  // Arrays: contents kept inside the block so that reads show the
  // result of programming and erasing; the EEPROM array has no reset,
  // as the cells keep their charge across a reset
  logic [7:0] ee_array [EEPROM_BYTES_L];
  logic [7:0] ep_array [EP_DEPTH];

  // Decoded strobes, indices and the erase mode
  logic                  wr_ee_ctl;
  logic                  wr_ep_ctl;
  logic                  ee_in_range;
  logic [EE_INDEX_W-1:0] ee_index;
  logic [EE_INDEX_W-1:0] ee_latched_index;
  logic [1:0]            ee_latched_block;
  epc_pkg::epc_mode_type erase_mode;

  // Register writes are decoded by full address; the other offsets
  // belong to neighbouring blocks and are ignored here
  assign wr_ee_ctl = reg_write &&
                     (reg_addr == epc_pkg::EEPROM_PROGRAM_CONTROL_ADDR);
  assign wr_ep_ctl = reg_write &&
                     (reg_addr == epc_pkg::EPROM_PROGRAM_CONTROL_ADDR);
  // Only the mapped bytes count as EEPROM; the short last block ends
  // early, and the gap above it is not part of the array
  assign ee_in_range = (ee_addr >= epc_pkg::EEPROM_BASE) &&
                       (ee_addr <= epc_pkg::EEPROM_LAST);
  assign ee_index = EE_INDEX_W'(ee_addr - epc_pkg::EEPROM_BASE);
  assign ee_latched_index =
    EE_INDEX_W'(ee_latched_addr - epc_pkg::EEPROM_BASE);
  // Block of the latched address: the index bits above the block size
  assign ee_latched_block = 2'(ee_latched_index >> epc_pkg::BLOCK_BITS);
  // Erase field seen as an operation code
  assign erase_mode = epc_pkg::epc_mode_type'(erase_select);

  // Charge pump enable bit; the pump alone never reaches the cells,
  // the power bit gates it again at the array side
  always_ff @(posedge clk) begin
    if (srst) begin
      charge_pump_enable <= 1'b0;
    end else if (wr_ee_ctl) begin
      charge_pump_enable <= reg_wdata[epc_pkg::CHARGE_PUMP_ENABLE_BIT];
    end
  end

  // Erase select field, cleared by reset to program mode
  always_ff @(posedge clk) begin
    if (srst) begin
      erase_select <= 2'h0;
    end else if (wr_ee_ctl) begin
      erase_select <= {reg_wdata[epc_pkg::ERASE_SELECT_HIGH_BIT],
                       reg_wdata[epc_pkg::ERASE_SELECT_LOW_BIT]};
    end
  end

  // EEPROM latch control bit; clearing it also drops power at once
  always_ff @(posedge clk) begin
    if (srst) begin
      eeprom_latch <= 1'b0;
    end else if (wr_ee_ctl) begin
      eeprom_latch <= reg_wdata[epc_pkg::EEPROM_LATCH_BIT];
    end
  end

  // RC clock select; software owns the start-up wait after setting it,
  // the block does not count it
  always_ff @(posedge clk) begin
    if (srst) begin
      rc_clock_select <= 1'b0;
    end else if (wr_ee_ctl) begin
      rc_clock_select <= reg_wdata[epc_pkg::RC_CLOCK_SELECT_BIT];
    end
  end

  // EEPROM power bit: set only with latch already set, cleared with latch
  // The write that raises it must keep the latch set, so one write can
  // never raise latch and power together, and a write that drops the
  // latch drops power in the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      eeprom_power_apply <= 1'b0;
    end else if (wr_ee_ctl) begin
      eeprom_power_apply <= eeprom_latch &&
        reg_wdata[epc_pkg::EEPROM_LATCH_BIT] &&
        reg_wdata[epc_pkg::EEPROM_POWER_APPLY_BIT];
    end else if (!eeprom_latch) begin
      eeprom_power_apply <= 1'b0;
    end
  end

  // EPROM capture bit, cleared by reset
  always_ff @(posedge clk) begin
    if (srst) begin
      eprom_bus_capture <= 1'b0;
    end else if (wr_ep_ctl) begin
      eprom_bus_capture <= reg_wdata[epc_pkg::EPROM_BUS_CAPTURE_BIT];
    end
  end

  // EPROM power bit with the same interlock as the EEPROM one: it needs
  // the capture bit already set and kept set by the same write, so a
  // single write can never raise both, and it falls with capture
  always_ff @(posedge clk) begin
    if (srst) begin
      eprom_power_apply <= 1'b0;
    end else if (wr_ep_ctl) begin
      eprom_power_apply <= eprom_bus_capture &&
        reg_wdata[epc_pkg::EPROM_BUS_CAPTURE_BIT] &&
        reg_wdata[epc_pkg::EPROM_POWER_APPLY_BIT];
    end else if (!eprom_bus_capture) begin
      eprom_power_apply <= 1'b0;
    end
  end

  // Upper EPROM register bits keep whatever software wrote, not reset
  // They read back undefined until software first writes them
  always_ff @(posedge clk) begin
    if (wr_ep_ctl) begin
      eprom_upper_bits <= reg_wdata[7:2];
    end
  end

  // Register read data, one cycle after the read strobe
  // Outside the answer cycle the port reads zero, so a stale value can
  // never be taken for a fresh one; unused EEPROM register bits read zero
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        epc_pkg::EEPROM_PROGRAM_CONTROL_ADDR:
          reg_rdata <= {1'b0, charge_pump_enable, 1'b0, erase_select,
                        eeprom_latch, rc_clock_select,
                        eeprom_power_apply};
        epc_pkg::EPROM_PROGRAM_CONTROL_ADDR:
          reg_rdata <= {eprom_upper_bits, eprom_bus_capture,
                        eprom_power_apply};
        default:
          reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // EEPROM capture: with latch set, a write lands in the latches
  // Once power is on the latches are frozen, so the byte being worked on
  // cannot change in the middle of a pulse
  always_ff @(posedge clk) begin
    if (srst) begin
      ee_latched_addr <= '0;
      ee_latched_data <= 8'h00;
      ee_latch_valid  <= 1'b0;
    end else if (!eeprom_latch) begin
      ee_latch_valid  <= 1'b0;
    end else if (ee_write && ee_in_range && !eeprom_power_apply) begin
      ee_latched_addr <= ee_addr;
      ee_latched_data <= ee_wdata;
      ee_latch_valid  <= 1'b1;
    end
  end

  // EEPROM array: normal writes, and program or erase under power
  // The operation repeats on every powered cycle; that is harmless, as
  // each pass writes the same values, and the pulse length stays with
  // software. Nothing happens without a captured address.
  always_ff @(posedge clk) begin
    if (!eeprom_latch) begin
      if (ee_write && ee_in_range) begin
        ee_array[ee_index] <= ee_wdata;
      end
    end else if (eeprom_power_apply && charge_pump_enable &&
                 ee_latch_valid) begin
      case (erase_mode)
        epc_pkg::EPC_MODE_PROGRAM:
          ee_array[ee_latched_index] <= ee_latched_data;
        epc_pkg::EPC_MODE_BYTE_ERASE:
          ee_array[ee_latched_index] <= epc_pkg::EEPROM_ERASED;
        epc_pkg::EPC_MODE_BLOCK_ERASE: begin
          for (int i = 0; i < EEPROM_BYTES_L; i++) begin
            if ((i >> epc_pkg::BLOCK_BITS) ==
                int'(ee_latched_block)) begin
              ee_array[i] <= epc_pkg::EEPROM_ERASED;
            end
          end
        end
        epc_pkg::EPC_MODE_BULK_ERASE: begin
          for (int i = 0; i < EEPROM_BYTES_L; i++) begin
            ee_array[i] <= epc_pkg::EEPROM_ERASED;
          end
        end
        default: ;
      endcase
    end
  end

  // EEPROM read data, blocked while latch is set
  // A blocked or idle read answers zero rather than array contents
  always_ff @(posedge clk) begin
    if (srst) begin
      ee_rdata <= 8'h00;
    end else if (ee_read && ee_in_range && !eeprom_latch) begin
      ee_rdata <= ee_array[ee_index];
    end else begin
      ee_rdata <= 8'h00;
    end
  end

  // EPROM capture latches
  // As on the EEPROM side, they freeze while power is on so that the
  // programmed byte cannot move during a pulse
  always_ff @(posedge clk) begin
    if (srst) begin
      eprom_latched_addr <= '0;
      eprom_latched_data <= 8'h00;
      eprom_latch_valid  <= 1'b0;
    end else if (!eprom_bus_capture) begin
      eprom_latch_valid  <= 1'b0;
    end else if (ep_write && !eprom_power_apply) begin
      eprom_latched_addr <= ep_addr;
      eprom_latched_data <= ep_wdata;
      eprom_latch_valid  <= 1'b1;
    end
  end

  // EPROM programming only drives bits toward one
  // Erased cells read zero; a pulse can set bits but never clear them,
  // so a second pass over the same byte ORs in the new data
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < EP_DEPTH; i++) begin
        ep_array[i] <= epc_pkg::EPROM_ERASED;
      end
    end else if (eprom_power_apply && eprom_latch_valid) begin
      ep_array[eprom_latched_addr[7:0]] <=
        ep_array[eprom_latched_addr[7:0]] | eprom_latched_data;
    end
  end

  // EPROM read data, blocked while capture is set
  // Only the low address bits index the modelled array
  always_ff @(posedge clk) begin
    if (srst) begin
      ep_rdata <= 8'h00;
    end else if (ep_read && !eprom_bus_capture) begin
      ep_rdata <= ep_array[ep_addr[7:0]];
    end else begin
      ep_rdata <= 8'h00;
    end
  end

  // Pump output follows the enable bit
  always_ff @(posedge clk) begin
    if (srst) begin
      charge_pump_on <= 1'b0;
    end else begin
      charge_pump_on <= charge_pump_enable;
    end
  end

  // EEPROM array power needs the power bit, the latch and a running
  // pump; a cleared latch cuts power in the same cycle either way,
  // as the power bit falls with it, so the latch term only repeats that
  always_ff @(posedge clk) begin
    if (srst) begin
      eeprom_power <= 1'b0;
    end else begin
      eeprom_power <= eeprom_power_apply && eeprom_latch &&
                      charge_pump_enable;
    end
  end

  // RC clock request towards the oscillator
  always_ff @(posedge clk) begin
    if (srst) begin
      rc_clock_on <= 1'b0;
    end else begin
      rc_clock_on <= rc_clock_select;
    end
  end

  // EPROM array power needs the power bit and the capture bit; the
  // external programming voltage itself is the board's business
  always_ff @(posedge clk) begin
    if (srst) begin
      eprom_power <= 1'b0;
    end else begin
      eprom_power <= eprom_power_apply && eprom_bus_capture;
    end
  end

endmodule

// ---- verif/epc_program_control_chk.sv ----
// Port checker for the program control block
`timescale 1ns/1ps
module epc_program_control_chk #(
  parameter int ADDR_WIDTH = 16
) (
  input wire logic                  clk,
  input wire logic                  srst,
  input wire logic [7:0]            reg_addr,
  input wire logic [7:0]            reg_wdata,
  input wire logic                  reg_write,
  input wire logic                  reg_read,
  input wire logic [7:0]            reg_rdata,
  input wire logic                  ee_read,
  input wire logic [7:0]            ee_rdata,
  input wire logic                  ep_read,
  input wire logic [7:0]            ep_rdata,
  input wire logic                  charge_pump_on,
  input wire logic                  eeprom_power,
  input wire logic                  rc_clock_on,
  input wire logic                  eprom_power
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic ee_lat;
  logic ep_lat;
  logic w_ee;
  logic w_ep;
  // Writes to each control register
  assign w_ee = reg_write && reg_addr == epc_pkg::EEPROM_PROGRAM_CONTROL_ADDR;
  assign w_ep = reg_write && reg_addr == epc_pkg::EPROM_PROGRAM_CONTROL_ADDR;
  // Shadow of the EEPROM latch bit
  always_ff @(posedge clk) begin
    if (srst) ee_lat <= 1'b0;
    else if (w_ee) ee_lat <= reg_wdata[2];
  end
  // Shadow of the EPROM capture bit
  always_ff @(posedge clk) begin
    if (srst) ep_lat <= 1'b0;
    else if (w_ep) ep_lat <= reg_wdata[1];
  end
  a_power_needs_pump: assert property (eeprom_power |-> charge_pump_on)
    else $error("array power without pump");
  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data outside answer cycle");
  a_rc_follows: assert property (w_ee |-> ##2
    rc_clock_on == $past(reg_wdata[1], 2)) else $error("rc select lost");
  a_ee_not_together: assert property (w_ee && reg_wdata[0] && !ee_lat
    |=> !eeprom_power [*2]) else $error("eeprom power set with latch");
  a_ee_clear_power: assert property (w_ee && !reg_wdata[2]
    |-> ##2 !eeprom_power) else $error("eeprom power kept");
  a_ee_read_block: assert property (ee_read && ee_lat |=>
    ee_rdata == 8'h00) else $error("eeprom read while latched");
  a_ep_not_together: assert property (w_ep && reg_wdata[0] && !ep_lat
    |=> !eprom_power [*2]) else $error("eprom power set with capture");
  a_ep_clear_power: assert property (w_ep && !reg_wdata[1]
    |-> ##2 !eprom_power) else $error("eprom power kept");
  a_ep_read_block: assert property (ep_read && ep_lat |=>
    ep_rdata == 8'h00) else $error("eprom read while captured");
endmodule
bind epc_program_control epc_program_control_chk #(
  .ADDR_WIDTH(ADDR_WIDTH)) u_chk (.clk(clk), .srst(srst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
  .reg_read(reg_read), .reg_rdata(reg_rdata), .ee_read(ee_read),
  .ee_rdata(ee_rdata), .ep_read(ep_read), .ep_rdata(ep_rdata),
  .charge_pump_on(charge_pump_on), .eeprom_power(eeprom_power),
  .rc_clock_on(rc_clock_on), .eprom_power(eprom_power));

// ---- verif/epc_supply_model.sv ----
// Programming supply model counting powered cycles of each array
`timescale 1ns/1ps
module epc_supply_model (
  input  wire logic clk,
  input  wire logic eeprom_power,
  input  wire logic eprom_power,
  output int        ee_cycles,
  output int        ep_cycles
);
  initial ee_cycles = 0;
  initial ep_cycles = 0;
  // Accumulate pulse length while power reaches an array
  always @(posedge clk) begin
    if (eeprom_power) ee_cycles <= ee_cycles + 1;
    if (eprom_power) ep_cycles <= ep_cycles + 1;
  end
endmodule

// ---- verif/test_epc_program_control.sv ----
// Testbench for the EEPROM and EPROM program control block
`timescale 1ns/1ps
module test_epc_program_control;
  localparam logic [7:0] EE = epc_pkg::EEPROM_PROGRAM_CONTROL_ADDR;
  localparam logic [7:0] EP = epc_pkg::EPROM_PROGRAM_CONTROL_ADDR;
  localparam int RC_WAIT = 4; // RC start-up wait in cycles, plain default
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  ra = 8'h00, rw = 8'h00, rd, ew = 8'h00, er, pw = 8'h00, pr;
  logic        rwr = 1'b0, rrd = 1'b0, ewr = 1'b0, erd = 1'b0;
  logic        pwr = 1'b0, prd = 1'b0;
  logic [15:0] ea = 16'h0000, pa = 16'h0000, lat_a;
  logic        pump, ee_pwr, rc_on, ep_pwr, lat_v;
  logic [7:0]  lat_d, d;
  int          ee_cyc, ep_cyc, cycles = 0, bad_count = 0, tests_run = 0;
  epc_program_control u_dut (.clk(clk), .srst(srst), .reg_addr(ra),
    .reg_wdata(rw), .reg_write(rwr), .reg_read(rrd), .reg_rdata(rd),
    .ee_addr(ea), .ee_wdata(ew), .ee_write(ewr), .ee_read(erd),
    .ee_rdata(er), .ep_addr(pa), .ep_wdata(pw), .ep_write(pwr),
    .ep_read(prd), .ep_rdata(pr), .charge_pump_on(pump),
    .eeprom_power(ee_pwr), .rc_clock_on(rc_on), .eprom_power(ep_pwr),
    .eprom_latched_addr(lat_a), .eprom_latched_data(lat_d),
    .eprom_latch_valid(lat_v));
  epc_supply_model u_supply (.clk(clk), .eeprom_power(ee_pwr),
    .eprom_power(ep_pwr), .ee_cycles(ee_cyc), .ep_cycles(ep_cyc));
  initial forever #4 clk = ~clk;
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Bus cycles: strobe for one cycle, read data taken in the next
  task automatic reg_wr(logic [7:0] a, logic [7:0] v);
    @(posedge clk); ra <= a; rw <= v; rwr <= 1'b1;
    @(posedge clk); rwr <= 1'b0;
  endtask
  task automatic reg_rd(logic [7:0] a, output logic [7:0] v);
    @(posedge clk); ra <= a; rrd <= 1'b1;
    @(posedge clk); rrd <= 1'b0; #1 v = rd;
  endtask
  task automatic ee_wr(logic [15:0] a, logic [7:0] v);
    @(posedge clk); ea <= a; ew <= v; ewr <= 1'b1;
    @(posedge clk); ewr <= 1'b0;
  endtask
  task automatic ee_rd(logic [15:0] a, output logic [7:0] v);
    @(posedge clk); ea <= a; erd <= 1'b1;
    @(posedge clk); erd <= 1'b0; #1 v = er;
  endtask
  task automatic ep_wr(logic [15:0] a, logic [7:0] v);
    @(posedge clk); pa <= a; pw <= v; pwr <= 1'b1;
    @(posedge clk); pwr <= 1'b0;
  endtask
  task automatic ep_rd(logic [15:0] a, output logic [7:0] v);
    @(posedge clk); pa <= a; prd <= 1'b1;
    @(posedge clk); prd <= 1'b0; #1 v = pr;
  endtask
  // Pump and latch together, capture, then power in a later write
  task automatic ee_op(logic [1:0] m, logic [15:0] a, logic [7:0] v);
    reg_wr(EE, {3'b010, m, 3'b100});
    ee_wr(a, v);
    reg_wr(EE, {3'b010, m, 3'b101});
    repeat (4) @(posedge clk);
    reg_wr(EE, 8'h00);
  endtask
  task automatic ep_op(logic [15:0] a, logic [7:0] v);
    reg_wr(EP, 8'h02);
    ep_wr(a, v);
    reg_wr(EP, 8'h03);
    repeat (4) @(posedge clk);
    reg_wr(EP, 8'h00);
  endtask
  task automatic test_regs();
    reg_rd(EE, d); chk("ee ctl reset", d, 8'h00);
    reg_rd(EP, d); chk("ep ctl reset", d & 8'h03, 8'h00);
    reg_rd(8'h1D, d); chk("unmapped read", d, 8'h00);
    for (int m = 0; m < 4; m++) begin
      reg_wr(EE, {3'b000, m[1:0], 3'b010});
      reg_rd(EE, d); chk("erase field", d, {3'b000, m[1:0], 3'b010});
      chk("rc clock", rc_on, 1'b1);
    end
    reg_wr(EE, 8'h05); @(posedge clk); #1 chk("power", ee_pwr, 1'b0);
    reg_rd(EE, d); chk("power bit refused", d, 8'h04);
    reg_wr(EE, 8'h00);
    $display("test regs done");
  endtask
  task automatic test_eeprom();
    ee_op(2'b11, 16'h0300, 8'h00);
    for (int i = 0; i < 240; i += 59) begin
      ee_rd(16'h0300 + 16'(i), d); chk("bulk erase", d, 8'h00);
    end
    reg_wr(EE, 8'h46); repeat (RC_WAIT) @(posedge clk);
    ee_wr(16'h0310, 8'h5A);
    ee_rd(16'h0310, d); chk("read latched", d, 8'h00);
    reg_wr(EE, 8'h47); @(posedge clk); #1 chk("pump", pump, 1'b1);
    chk("ee power", ee_pwr, 1'b1);
    chk("rc on", rc_on, 1'b1);
    repeat (3) @(posedge clk);
    reg_wr(EE, 8'h00); @(posedge clk); #1 chk("off", ee_pwr, 1'b0);
    chk("pump off", pump, 1'b0);
    ee_rd(16'h0310, d); chk("programmed", d, 8'h5A);
    ee_op(2'b00, 16'h0305, 8'hA5);
    ee_op(2'b00, 16'h0345, 8'h3C);
    ee_op(2'b00, 16'h0385, 8'h96);
    ee_op(2'b01, 16'h0305, 8'h00);
    ee_rd(16'h0305, d); chk("byte erased", d, 8'h00);
    ee_rd(16'h0345, d); chk("byte kept", d, 8'h3C);
    ee_op(2'b10, 16'h037F, 8'h00);
    ee_rd(16'h0345, d); chk("block erased", d, 8'h00);
    ee_rd(16'h0385, d); chk("block kept", d, 8'h96);
    chk("pulses seen", 16'(ee_cyc > 0), 16'h0001);
    $display("test eeprom done");
  endtask
  task automatic test_eprom();
    reg_wr(EP, 8'h02); ep_wr(16'h0012, 8'h5A);
    ep_rd(16'h0012, d); chk("ep read captured", d, 8'h00);
    chk("ep addr", lat_a, 16'h0012);
    chk("ep data", {lat_v, lat_d}, 16'h015A);
    reg_wr(EP, 8'h03); @(posedge clk); #1 chk("ep pwr", ep_pwr, 1'b1);
    repeat (4) @(posedge clk);
    reg_wr(EP, 8'h00); @(posedge clk); #1 chk("ep off", ep_pwr, 1'b0);
    ep_op(16'h0012, 8'h21);
    ep_rd(16'h0012, d); chk("ep bits or", d, 8'h7B);
    reg_wr(EP, 8'h03); @(posedge clk); #1 chk("ep both", ep_pwr, 1'b0);
    reg_rd(EP, d); chk("ep refused", d & 8'h03, 8'h02);
    reg_wr(EP, 8'h00);
    $display("test eprom done");
  endtask
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      close_out();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    test_regs();
    test_eeprom();
    test_eprom();
    close_out();
  end
endmodule
